// ==== hdl/periph_irq_pkg.sv ====
// Package with register map, field positions and types of the peripheral interrupt block
package periph_irq_pkg;
	localparam logic [11:0] ENABLE_OFFSET   = 12'h08c;
	localparam logic [11:0] FLAG_OFFSET     = 12'h00c;
	localparam logic [11:0] CONTROL_OFFSET  = 12'h100;
	localparam logic [11:0] STATUS_OFFSET   = 12'h104;
	localparam logic [11:0] CLEAR_OFFSET    = 12'h108;
	localparam logic [11:0] IRQ_EN_OFFSET   = 12'h10c;
	localparam int          LCD_BIT         = 7;
	localparam int          CONV_BIT        = 6;
	localparam int          SERIAL_BIT      = 3;
	localparam int          CAPCMP_BIT      = 2;
	localparam int          PERIOD_BIT      = 1;
	localparam int          OVERFLOW_BIT    = 0;
	localparam int          GLOBAL_BIT      = 7;
	localparam int          GROUP_BIT       = 6;
	localparam logic [7:0]  IMPL_MASK       = 8'hcf;
	localparam logic [7:0]  CONTROL_MASK    = 8'hc0;
	localparam logic [7:0]  REG_RESET       = 8'h00;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
	localparam int          STATUS_PENDING  = 0;
	localparam int          STATUS_NEWFLAG  = 1;
	localparam logic [1:0]  STATUS_MASK     = 2'b11;

	typedef struct packed {
		logic       valid;
		logic [1:0] resp;
	} bus_resp_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
		logic [1:0]  resp;
	} bus_rdata_t;
endpackage

// ==== hdl/periph_irq.sv ====
// Peripheral interrupt enable and flag registers behind an AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - bit 7 enable gates LCD request
// - bit 6 enable gates converter request
// - one flag bit per peripheral source
// - flags set regardless of any enable
// - group enable bit 6 required for request
// - flags stay set until software clears
module periph_irq
	import periph_irq_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// AXI4-Lite write address and data
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Peripheral condition pulses, bit order as the flag register
	input  wire logic [7:0]  periph_event,
	// Request to the core and block interrupt
	output logic             periph_irq_req,
	output logic             irq
);
	logic [7:0]  peripheral_irq_enable_reg;
	logic [7:0]  peripheral_irq_flag_reg;
	logic [7:0]  irq_control_reg;
	logic [1:0]  status_reg;
	logic [1:0]  irq_en_reg;
	logic [11:0] aw_addr_reg;
	logic        aw_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        w_have_reg;
	bus_resp_t   b_reg;
	bus_rdata_t  r_reg;
	logic        wr_fire;
	logic        wr_lane0;
	logic        flag_wr;
	logic        clear_wr;
	logic [7:0]  event_in;
	logic [7:0]  pending;
	logic        req_next;
	logic [1:0]  status_evt;

	assign s_axi_bvalid = b_reg.valid;
	assign s_axi_bresp  = b_reg.resp;
	assign s_axi_rvalid = r_reg.valid;
	assign s_axi_rdata  = r_reg.data;
	assign s_axi_rresp  = r_reg.resp;

	// Write channel capture, address and data in either order
	assign wr_fire  = aw_have_reg && w_have_reg && !b_reg.valid;
	assign wr_lane0 = wr_fire && w_strb_reg[0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_reg   <= 1'b0;
			aw_addr_reg   <= 12'h000;
			s_axi_awready <= 1'b0;
		end else if (wr_fire) begin
			aw_have_reg   <= 1'b0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_reg   <= 1'b1;
			aw_addr_reg   <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w_have_reg   <= 1'b0;
			w_data_reg   <= 32'h0000_0000;
			w_strb_reg   <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (wr_fire) begin
			w_have_reg   <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_reg   <= 1'b1;
			w_data_reg   <= s_axi_wdata;
			w_strb_reg   <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			b_reg <= '{valid: 1'b0, resp: RESP_OKAY};
		end else if (wr_fire) begin
			b_reg.valid <= 1'b1;
			unique case (aw_addr_reg)
				ENABLE_OFFSET, FLAG_OFFSET, CONTROL_OFFSET, STATUS_OFFSET,
				CLEAR_OFFSET, IRQ_EN_OFFSET: b_reg.resp <= RESP_OKAY;
				default:                     b_reg.resp <= RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			b_reg.valid <= 1'b0;
		end
	end

	// Register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			peripheral_irq_enable_reg <= REG_RESET;
		end else if (wr_lane0 && aw_addr_reg == ENABLE_OFFSET) begin
			peripheral_irq_enable_reg <= w_data_reg[7:0] & IMPL_MASK;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_control_reg <= REG_RESET;
		end else if (wr_lane0 && aw_addr_reg == CONTROL_OFFSET) begin
			irq_control_reg <= w_data_reg[7:0] & CONTROL_MASK;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_reg <= 2'b00;
		end else if (wr_lane0 && aw_addr_reg == IRQ_EN_OFFSET) begin
			irq_en_reg <= w_data_reg[1:0] & STATUS_MASK;
		end
	end

	// Flags: set by condition, hold until software writes zero; set wins
	assign event_in = periph_event & IMPL_MASK;
	assign flag_wr  = wr_lane0 && aw_addr_reg == FLAG_OFFSET;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			peripheral_irq_flag_reg <= REG_RESET;
		end else if (flag_wr) begin
			peripheral_irq_flag_reg <= (w_data_reg[7:0] & IMPL_MASK) | event_in;
		end else begin
			peripheral_irq_flag_reg <= peripheral_irq_flag_reg | event_in;
		end
	end

	// Gating: enable per source, then group enable
	assign pending  = peripheral_irq_flag_reg & peripheral_irq_enable_reg;
	assign req_next = |pending && irq_control_reg[GROUP_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_irq_req <= 1'b0;
		end else begin
			periph_irq_req <= req_next;
		end
	end

	// Sticky block status: request seen, new flag seen
	assign clear_wr   = wr_lane0 && aw_addr_reg == CLEAR_OFFSET;
	assign status_evt = {|event_in, req_next};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= 2'b00;
		end else if (clear_wr) begin
			status_reg <= (status_reg & ~w_data_reg[1:0]) | status_evt;
		end else begin
			status_reg <= status_reg | status_evt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_reg & irq_en_reg);
		end
	end

	// Read channel, one cycle after address is taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !r_reg.valid;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '{valid: 1'b0, data: 32'h0000_0000, resp: RESP_OKAY};
		end else if (s_axi_arvalid && s_axi_arready) begin
			r_reg.valid <= 1'b1;
			r_reg.resp  <= RESP_OKAY;
			unique case (s_axi_araddr)
				ENABLE_OFFSET:  r_reg.data <= {24'h000000, peripheral_irq_enable_reg};
				FLAG_OFFSET:    r_reg.data <= {24'h000000, peripheral_irq_flag_reg};
				CONTROL_OFFSET: r_reg.data <= {24'h000000, irq_control_reg};
				STATUS_OFFSET:  r_reg.data <= {30'h0, status_reg};
				CLEAR_OFFSET:   r_reg.data <= 32'h0000_0000;
				IRQ_EN_OFFSET:  r_reg.data <= {30'h0, irq_en_reg};
				default: begin
					r_reg.data <= 32'h0000_0000;
					r_reg.resp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			r_reg.valid <= 1'b0;
		end
	end

	// Checks
	property p_flag_sets;
		@(posedge clk) disable iff (!rst_n)
		periph_event[LCD_BIT] |=> peripheral_irq_flag_reg[LCD_BIT];
	endproperty
	a_flag_sets: assert property (p_flag_sets) else $error("flag not set");

	property p_flag_holds;
		@(posedge clk) disable iff (!rst_n)
		(peripheral_irq_flag_reg[CONV_BIT] && !flag_wr) |=> peripheral_irq_flag_reg[CONV_BIT];
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("flag dropped");

	property p_lcd_gate;
		@(posedge clk) disable iff (!rst_n)
		(peripheral_irq_flag_reg[LCD_BIT] && !peripheral_irq_enable_reg[LCD_BIT]
			&& (peripheral_irq_flag_reg & peripheral_irq_enable_reg) == 8'h00)
			|=> !periph_irq_req;
	endproperty
	a_lcd_gate: assert property (p_lcd_gate) else $error("lcd not gated");

	property p_capcmp_block;
		@(posedge clk) disable iff (!rst_n)
		(peripheral_irq_flag_reg[CAPCMP_BIT] && !peripheral_irq_enable_reg[CAPCMP_BIT]
			&& (peripheral_irq_flag_reg & peripheral_irq_enable_reg) == 8'h00)
			|=> !periph_irq_req;
	endproperty
	a_capcmp_block: assert property (p_capcmp_block) else $error("capcmp not gated");

	property p_serial_pass;
		@(posedge clk) disable iff (!rst_n)
		(peripheral_irq_flag_reg[SERIAL_BIT] && peripheral_irq_enable_reg[SERIAL_BIT]
			&& irq_control_reg[GROUP_BIT]) |=> periph_irq_req;
	endproperty
	a_serial_pass: assert property (p_serial_pass) else $error("serial blocked");

	property p_period_pass;
		@(posedge clk) disable iff (!rst_n)
		(peripheral_irq_flag_reg[PERIOD_BIT] && peripheral_irq_enable_reg[PERIOD_BIT]
			&& irq_control_reg[GROUP_BIT]) |=> periph_irq_req;
	endproperty
	a_period_pass: assert property (p_period_pass) else $error("period blocked");

	property p_conv_pass;
		@(posedge clk) disable iff (!rst_n)
		(peripheral_irq_flag_reg[CONV_BIT] && peripheral_irq_enable_reg[CONV_BIT]
			&& irq_control_reg[GROUP_BIT]) |=> periph_irq_req;
	endproperty
	a_conv_pass: assert property (p_conv_pass) else $error("converter blocked");

	property p_group;
		@(posedge clk) disable iff (!rst_n)
		!irq_control_reg[GROUP_BIT] |=> !periph_irq_req;
	endproperty
	a_group: assert property (p_group) else $error("group gate open");

	property p_unused_bits;
		@(posedge clk) disable iff (!rst_n)
		peripheral_irq_enable_reg[5:4] == 2'b00 && peripheral_irq_flag_reg[5:4] == 2'b00;
	endproperty
	a_unused_bits: assert property (p_unused_bits) else $error("unused bit set");

	property p_low_pass;
		@(posedge clk) disable iff (!rst_n)
		(peripheral_irq_flag_reg[OVERFLOW_BIT] && peripheral_irq_enable_reg[OVERFLOW_BIT]
			&& irq_control_reg[GROUP_BIT]) |=> periph_irq_req;
	endproperty
	a_low_pass: assert property (p_low_pass) else $error("overflow blocked");

	property p_no_self_clear;
		@(posedge clk) disable iff (!rst_n)
		!flag_wr |=> (peripheral_irq_flag_reg & $past(peripheral_irq_flag_reg))
			== $past(peripheral_irq_flag_reg);
	endproperty
	a_no_self_clear: assert property (p_no_self_clear) else $error("flag cleared");

	property p_irq_high;
		@(posedge clk) disable iff (!rst_n)
		(|(status_reg & irq_en_reg)) |=> irq;
	endproperty
	a_irq_high: assert property (p_irq_high) else $error("irq missing");

	property p_irq_low;
		@(posedge clk) disable iff (!rst_n)
		!(|(status_reg & irq_en_reg)) |=> !irq;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("irq without cause");
endmodule

// ==== verification/periph_irq_tb_top.sv ====
// Self-checking testbench of the peripheral interrupt block over AXI4-Lite
`timescale 1ns/1ps
module periph_irq_tb_top;
	import periph_irq_pkg::*;
	logic        clk = 0;
	logic        rst_n = 0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0]  wstrb = '0;
	logic [3:0]  wr_strb = 4'hf;
	logic        awready, wready, bvalid, arready, rvalid, irq_req, irq;
	logic [1:0]  bresp, rresp;
	logic [7:0]  periph_event = '0;
	int          error_cnt = 0;
	int          comparisons = 0;

	always #2.5 clk = ~clk;

	periph_irq dut (
		.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph_event(periph_event),
		.periph_irq_req(irq_req), .irq(irq)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Address and data offered together, each released once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= wr_strb;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		check(32'(bresp), 32'(RESP_OKAY));
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		check(rdata, exp);
		check(32'(rresp), 32'(er));
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
	endtask

	task automatic pulse(input logic [7:0] m);
		@(posedge clk);
		periph_event <= m;
		@(posedge clk);
		periph_event <= 8'h00;
		settle();
	endtask

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end

	initial begin
		logic [7:0] src [6];
		src = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 8'h01};
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(ENABLE_OFFSET, 32'h0, RESP_OKAY);
		rd(FLAG_OFFSET, 32'h0, RESP_OKAY);
		wr(ENABLE_OFFSET, 32'hffff_ffff);
		rd(ENABLE_OFFSET, 32'hcf, RESP_OKAY);
		// Lane 0 strobe low leaves the register alone
		wr_strb = 4'he;
		wr(ENABLE_OFFSET, 32'h0);
		wr_strb = 4'hf;
		rd(ENABLE_OFFSET, 32'hcf, RESP_OKAY);
		rd(12'h200, 32'h0, RESP_SLVERR);
		wr(ENABLE_OFFSET, 32'h0);
		// Conditions latch with every enable and the global bit low
		pulse(8'hff);
		check(32'(irq_req), 32'h0);
		rd(FLAG_OFFSET, 32'hcf, RESP_OKAY);
		repeat (10) @(posedge clk);
		rd(FLAG_OFFSET, 32'hcf, RESP_OKAY);
		wr(FLAG_OFFSET, 32'h0);
		rd(FLAG_OFFSET, 32'h0, RESP_OKAY);
		wr(CONTROL_OFFSET, 32'h40);
		rd(CONTROL_OFFSET, 32'h40, RESP_OKAY);
		for (int i = 0; i < 6; i++) begin
			wr(FLAG_OFFSET, 32'h0);
			wr(ENABLE_OFFSET, 32'(src[i]));
			pulse(IMPL_MASK & ~src[i]);
			check(32'(irq_req), 32'h0);
			pulse(src[i]);
			check(32'(irq_req), 32'h1);
		end
		// Group enable low blocks a pending enabled flag
		wr(CONTROL_OFFSET, 32'h0);
		settle();
		check(32'(irq_req), 32'h0);
		wr(CONTROL_OFFSET, 32'h40);
		settle();
		check(32'(irq_req), 32'h1);
		wr(CONTROL_OFFSET, 32'h0);
		// Block interrupt: raise, mask, unmask, clear
		rd(STATUS_OFFSET, 32'h3, RESP_OKAY);
		wr(CLEAR_OFFSET, 32'h3);
		wr(IRQ_EN_OFFSET, 32'h2);
		rd(IRQ_EN_OFFSET, 32'h2, RESP_OKAY);
		pulse(8'h02);
		check(32'(irq), 32'h1);
		rd(STATUS_OFFSET, 32'h2, RESP_OKAY);
		wr(IRQ_EN_OFFSET, 32'h0);
		settle();
		check(32'(irq), 32'h0);
		wr(IRQ_EN_OFFSET, 32'h2);
		settle();
		check(32'(irq), 32'h1);
		wr(CLEAR_OFFSET, 32'h3);
		settle();
		check(32'(irq), 32'h0);
		rd(STATUS_OFFSET, 32'h0, RESP_OKAY);
		give_verdict();
	end
endmodule
